//--- bench/adc_out_props.sv
// Checker on the pins and bus handshake of the converter interface.
// Sees only top-level ports; bound to every instance below.
`timescale 1ns/1ps
`include "adc_out_defs.vh"
module adc_out_props (
  input wire clk, // System clock
  input wire arst_n, // Reset, active low
  input wire [`WORD_W-1:0] sample_word_true, // Word, true legs
  input wire [`WORD_W-1:0] sample_word_comp, // Word, comp legs
  input wire range_flag_true, // Flag, true leg
  input wire range_flag_comp, // Flag, comp leg
  input wire fwd_clock_true, // Forwarded clock, true leg
  input wire fwd_clock_comp, // Forwarded clock, comp leg
  input wire rate_halving_select, // Rate pin level
  input wire rate_halving_driven, // Rate pin connected
  input wire read, // Bus read
  input wire write, // Bus write
  input wire waitrequest // Bus wait
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire full = rate_halving_select & rate_halving_driven;
  word_legs_a: assert property (sample_word_comp == ~sample_word_true)
    else $error("word legs not complementary");
  flag_legs_a: assert property (range_flag_comp == ~range_flag_true)
    else $error("flag legs not complementary");
  fwd_legs_a: assert property (fwd_clock_comp == ~fwd_clock_true)
    else $error("clock legs not complementary");
  flag_code_a: assert property (range_flag_true |->
    sample_word_true inside {8'hff, 8'h00, 8'h7f, 8'h80})
    else $error("flag set with an inner code");
  // Receiver latches on the forwarded rise, so the word must be settled
  fwd_stable_a: assert property (full && $rose(fwd_clock_true)
    |-> $stable(sample_word_true)) else $error("word moves at clock rise");
  wait_first_a: assert property ($rose(read | write) |-> waitrequest)
    else $error("no wait state on a new request");
  wait_one_a: assert property ((read | write) && waitrequest |=> !waitrequest)
    else $error("wait state longer than one cycle");
  idle_wait_a: assert property (!(read | write) |-> !waitrequest)
    else $error("wait raised while idle");
  cover property ($rose(range_flag_true));
  cover property ($rose(fwd_clock_true));
  cover property ((read | write) && !waitrequest);
endmodule
bind adc_sample_output_interface adc_out_props props_u (.clk(clk),
  .arst_n(arst_n), .sample_word_true(sample_word_true),
  .sample_word_comp(sample_word_comp), .range_flag_true(range_flag_true),
  .range_flag_comp(range_flag_comp), .fwd_clock_true(fwd_clock_true),
  .fwd_clock_comp(fwd_clock_comp), .rate_halving_select(rate_halving_select),
  .rate_halving_driven(rate_halving_driven), .read(read), .write(write),
  .waitrequest(waitrequest));

//--- bench/adc_rx_model.sv
// Receiver beside the converter: latches word and flag on each
// forwarded clock rise. Assumes the word is settled at that rise.
`timescale 1ns/1ps
module adc_rx_model (
  input wire fwd_clock_true, // Forwarded clock, true leg
  input wire [7:0] word, // Word lines, true legs
  input wire flag, // Range flag, true leg
  output reg [7:0] rx_word, // Last latched word
  output reg rx_flag, // Last latched flag
  output integer rx_count // Latches so far
);
  initial rx_count = 0;
  always @(posedge fwd_clock_true) begin
    rx_word <= word;
    rx_flag <= flag;
    rx_count <= rx_count + 1;
  end
endmodule

//--- bench/adc_sample_output_interface_tb.sv
// Bench for the converter interface: random and corner samples in
// every pin mode, then the register bus and interrupt. One clock.
`timescale 1ns/1ps
`include "adc_out_defs.vh"
module adc_sample_output_interface_tb;
  reg clk = 0, arst_n = 0, sct = 0, scc = 1, read = 0, write = 0;
  reg [9:0] ap = 10'h200;
  reg rsel = 1, rdrv = 1, fsel = 1, fdrv = 1, ob, chk;
  reg [2:0] address = 3'h0;
  reg [31:0] wdata = 32'h0, rd;
  reg [8:0] exp;
  wire [7:0] wt, wc, rx_word;
  wire ft, fc, dt, dc, wreq, irq, rx_flag;
  wire [31:0] rdata;
  integer rx_count, n_errors = 0, compares = 0, k = 0, base, c, m, i, d;
  integer hist [0:63];
  integer cn [0:5] = '{127, 128, -128, -129, 0, 300};
  always #25 clk = ~clk;
  adc_sample_output_interface dut_u (.clk(clk), .arst_n(arst_n),
    .sample_clock_true(sct), .sample_clock_comp(scc), .analog_in_pos(ap),
    .analog_in_neg(10'h200), .rate_halving_select(rsel),
    .rate_halving_driven(rdrv), .format_select(fsel), .format_driven(fdrv),
    .sample_word_true(wt), .sample_word_comp(wc), .range_flag_true(ft),
    .range_flag_comp(fc), .fwd_clock_true(dt), .fwd_clock_comp(dc),
    .address(address), .read(read), .write(write), .writedata(wdata),
    .byteenable(4'hf), .waitrequest(wreq), .readdata(rdata), .irq(irq));
  adc_rx_model rx_u (.fwd_clock_true(dt), .word(wt), .flag(ft),
    .rx_word(rx_word), .rx_flag(rx_flag), .rx_count(rx_count));
  task check(input [31:0] seen, input [31:0] want, input string what);
    begin
      compares = compares + 1;
      if (seen !== want) begin
        n_errors = n_errors + 1;
        $display("Error %s expected %h seen %h", what, want, seen);
      end
    end
  endtask
  function [8:0] code(input integer v, input bin);
    reg [7:0] b;
    begin
      if (v >= 127)
        b = 8'hff;
      else if (v <= -128)
        b = 8'h00;
      else
        b = v + 128;
      code = {v > 127 || v < -128, b ^ (bin ? 8'h00 : 8'h80)};
    end
  endfunction
  // Level is set a half period before the rise it is meant for
  task sample(input integer v);
    begin
      @(posedge clk);
      sct <= 0;
      scc <= 1;
      ap <= 10'h200 + v;
      hist[k % 64] = v;
      repeat (4) @(posedge clk);
      if (chk && k - base > 10) begin
        exp = code(hist[(k - 10) % 64], ob);
        check(rx_word, exp[7:0], "word");
        check(rx_flag, exp[8], "flag");
      end
      sct <= 1;
      scc <= 0;
      repeat (3) @(posedge clk);
      k = k + 1;
    end
  endtask
  task bus(input wr, input [2:0] a, input [31:0] v, output [31:0] q);
    begin
      @(posedge clk);
      address <= a;
      read <= !wr;
      write <= wr;
      wdata <= v;
      // Waitrequest is read as it stood at the edge, before that edge's update
      @(posedge clk);
      while (wreq !== 1'b0)
        @(posedge clk);
      q = rdata;
      read <= 0;
      write <= 0;
    end
  endtask
  task test_done;
    begin
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    #(50 * 6000);
    n_errors = n_errors + 1;
    test_done;
  end
  initial begin
    c = $urandom(95);
    repeat (20) @(posedge clk);
    arst_n <= 1;
    bus(0, `REG_CTRL, 0, rd);
    check(rd, 1, "ctrl");
    for (m = 0; m < 5; m = m + 1) begin
      @(posedge clk);
      rsel <= m != 3;
      rdrv <= m != 4;
      fsel <= m != 1;
      fdrv <= m != 2;
      ob = m == 0 || m > 2;
      chk = m < 3;
      base = k;
      for (i = 0; i < 28; i = i + 1) begin
        if (i == 12)
          c = rx_count;
        d = (i % 4 == 0) ? cn[(i / 4) % 6] : $urandom_range(280) - 140;
        sample(d);
      end
      check(rx_count - c, m < 3 ? 16 : 8, "updates");
    end
    bus(0, `REG_MASK, 0, rd);
    check(rd, 0, "mask");
    check(irq, 0, "irq masked");
    bus(1, `REG_MASK, 1, rd);
    @(negedge clk);
    check(irq, 1, "irq raised");
    bus(0, 3'h7, 0, rd);
    check(rd, 0, "unmapped");
    // Each sample call spans eight clock cycles
    bus(0, `REG_PERIOD, 0, rd);
    check(rd, 8, "period");
    bus(1, `REG_STATUS, 3, rd);
    bus(0, `REG_STATUS, 0, rd);
    check(rd, 0, "status");
    @(negedge clk);
    check(irq, 0, "irq cleared");
    test_done;
  end
endmodule

//--- hw/adc_out_defs.vh
// Constants for the converter output interface: offsets, fields, timing.
// Assumes a 20 MHz system clock; included by bare name.
`ifndef ADC_OUT_DEFS_VH
`define ADC_OUT_DEFS_VH

`define CLK_PERIOD_PS 50000
`define FWD_DELAY_PS 2100
// Rounds down, but never below one cycle
`define FWD_DELAY_CYC (((`FWD_DELAY_PS / `CLK_PERIOD_PS) < 1) ? 1 : \
  (`FWD_DELAY_PS / `CLK_PERIOD_PS))
`define MIN_SAMPLE_CLK_HZ 20000000
`define PIPE_LATENCY 9
`define WORD_W 8
`define LEVEL_W 10
`define DIFF_W 11
`define POS_FULL_SCALE 11'sh07f
`define NEG_FULL_SCALE (-11'sh080)
`define MID_OFFSET 11'h080
`define CODE_MAX 8'hff
`define CODE_MIN 8'h00
`define PERIOD_W 16

`define ADDR_W 3
`define REG_CTRL 3'h0
`define REG_STATUS 3'h1
`define REG_MASK 3'h2
`define REG_WORD 3'h3
`define REG_PERIOD 3'h4

`define CTRL_RUN_BIT 0
`define CTRL_RESET 32'h0000_0001
`define ST_RANGE_BIT 0
`define ST_UPDATE_BIT 1
`define ST_W 2

`endif

//--- hw/adc_sample_output_interface.v
// Functional notes
// - Input sample clock is regenerated as a 50% duty internal clock, always on.
// - Forwarded clock rises a fixed 2.1ns after each true sample clock rise; the model raises it six system clock edges after the pin rise.
// - Rate select low halves the output update rate.
// - Unconnected rate select reads as low, the halving state.
// - Rate select high updates output at the full input clock rate.
// - Sample taken on true clock rising edge, complementary falling edge.
// - Word emerges nine clock cycles after capture; receiver latches on next rise.
// - Format select low gives two's complement, high gives offset binary.
// - Unconnected format select reads as low, two's complement.
// - Range flag pair asserts only beyond positive or negative full scale.
// - At or over positive full scale output all ones, or 0111 1111.
// - At or under negative full scale output zeros, or 1000 0000.
// - Word bits, forwarded clock and range flag are true/complement pairs.
//
// Digital model of the converter output side on a 20 MHz system clock.
// Assumes pin inputs are asynchronous and registers sit on Avalon-MM.
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "adc_out_defs.vh"
module adc_sample_output_interface (
  input wire clk, // System clock, 20 MHz
  input wire arst_n, // Asynchronous reset, active low
  input wire sample_clock_true, // Sample clock, true leg
  input wire sample_clock_comp, // Sample clock, complementary leg
  input wire [`LEVEL_W-1:0] analog_in_pos, // Quantised positive input level
  input wire [`LEVEL_W-1:0] analog_in_neg, // Quantised negative input level
  input wire rate_halving_select, // Rate select pin level
  input wire rate_halving_driven, // High when the rate pin is connected
  input wire format_select, // Format select pin level
  input wire format_driven, // High when the format pin is connected
  output reg [`WORD_W-1:0] sample_word_true, // Output word, true legs
  output reg [`WORD_W-1:0] sample_word_comp, // Output word, comp legs
  output reg range_flag_true, // Out-of-range flag, true leg
  output reg range_flag_comp, // Out-of-range flag, comp leg
  output reg fwd_clock_true, // Forwarded data clock, true leg
  output reg fwd_clock_comp, // Forwarded data clock, comp leg
  input wire [`ADDR_W-1:0] address, // Avalon word address
  input wire read, // Avalon read request
  input wire write, // Avalon write request
  input wire [31:0] writedata, // Avalon write data
  input wire [3:0] byteenable, // Avalon byte enables
  output wire waitrequest, // Avalon wait, high until the answer
  output reg [31:0] readdata, // Avalon read data
  output wire irq // Level interrupt
);
  // Two-flop synchronisers for every pin
  localparam SYNC_W = 2 * `LEVEL_W + 6;
  reg [SYNC_W-1:0] meta_q;
  reg [SYNC_W-1:0] sync_q;
  wire [`LEVEL_W-1:0] pos_s;
  wire [`LEVEL_W-1:0] neg_s;
  wire clk_t_s;
  wire clk_c_s;
  wire rate_s;
  wire rate_drv_s;
  wire fmt_s;
  wire fmt_drv_s;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= {SYNC_W{1'b0}};
      sync_q <= {SYNC_W{1'b0}};
    end else begin
      meta_q <= {analog_in_pos, analog_in_neg, sample_clock_true,
                 sample_clock_comp, rate_halving_select, rate_halving_driven,
                 format_select, format_driven};
      sync_q <= meta_q;
    end
  end

  assign {pos_s, neg_s, clk_t_s, clk_c_s, rate_s, rate_drv_s, fmt_s,
          fmt_drv_s} = sync_q;

  // An open pin is pulled down, so it only counts when driven
  wire full_rate = rate_drv_s & rate_s;
  wire offset_bin = fmt_drv_s & fmt_s;

  // Register file
  reg [31:0] ctrl_q;
  reg [`ST_W-1:0] status_q;
  reg [`ST_W-1:0] mask_q;
  reg [`PERIOD_W-1:0] period_q;
  reg ack_q;
  wire run = ctrl_q[`CTRL_RUN_BIT];

  // Differential clock level; rising means true up and comp down
  reg lvl_q;
  wire diff_lvl = clk_t_s & ~clk_c_s;
  wire sample_edge = diff_lvl & ~lvl_q;

  // Duty-cycle equaliser: measure period, hold high for half of it
  reg [`PERIOD_W-1:0] cnt_q;
  reg eq_clk_q;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lvl_q <= 1'b0;
      cnt_q <= {`PERIOD_W{1'b0}};
      period_q <= {`PERIOD_W{1'b0}};
      eq_clk_q <= 1'b0;
    end else begin
      lvl_q <= diff_lvl;
      if (sample_edge) begin
        period_q <= cnt_q + 1'b1;
        cnt_q <= {`PERIOD_W{1'b0}};
        eq_clk_q <= 1'b1;
      end else begin
        if (cnt_q != {`PERIOD_W{1'b1}}) begin
          cnt_q <= cnt_q + 1'b1;
        end
        // Drop the level once the count reaches half the measured period
        if (cnt_q + 1'b1 >= {1'b0, period_q[`PERIOD_W-1:1]}) begin
          eq_clk_q <= 1'b0;
        end
      end
    end
  end

  // Divide-by-two stage for halved update rate
  reg div_q;
  reg eq_last_q;
  wire eq_rise = eq_clk_q & ~eq_last_q;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 1'b0;
      eq_last_q <= 1'b0;
    end else begin
      eq_last_q <= eq_clk_q;
      if (eq_rise) begin
        div_q <= ~div_q;
      end
    end
  end

  wire update = sample_edge & run & (full_rate | ~div_q);

  // Quantiser model: signed difference, clamp, overrange detect
  wire signed [`DIFF_W-1:0] diff = $signed({1'b0, pos_s}) -
                                   $signed({1'b0, neg_s});
  wire over_pos = diff > `POS_FULL_SCALE;
  wire over_neg = diff < `NEG_FULL_SCALE;
  reg [`WORD_W-1:0] code_bin;
  always @* begin
    if (diff >= `POS_FULL_SCALE) begin
      code_bin = `CODE_MAX;
    end else if (diff <= `NEG_FULL_SCALE) begin
      code_bin = `CODE_MIN;
    end else begin
      // Inside full scale, adding midscale is the same as flipping the top bit
      code_bin = diff[`WORD_W-1:0] ^ {1'b1, {(`WORD_W-1){1'b0}}};
    end
  end

  // Nine-stage pipeline clocked by every sample edge while run is set
  wire [`WORD_W:0] pipe_out;
  stage_delay #(
    .WIDTH(`WORD_W + 1),
    .DEPTH(`PIPE_LATENCY)
  ) u_pipe (
    .clk(clk),
    .arst_n(arst_n),
    .en(sample_edge & run),
    .din({over_pos | over_neg, code_bin}),
    .dout(pipe_out)
  );

  wire [`WORD_W-1:0] word_fmt = offset_bin ? pipe_out[`WORD_W-1:0] :
    {~pipe_out[`WORD_W-1], pipe_out[`WORD_W-2:0]};

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_word_true <= {`WORD_W{1'b0}};
      sample_word_comp <= {`WORD_W{1'b1}};
      range_flag_true <= 1'b0;
      range_flag_comp <= 1'b1;
    end else if (update) begin
      sample_word_true <= word_fmt;
      sample_word_comp <= ~word_fmt;
      range_flag_true <= pipe_out[`WORD_W];
      range_flag_comp <= ~pipe_out[`WORD_W];
    end
  end

  // Forwarded clock: equalised clock, halved when asked, then delayed
  reg fwd_src_q;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fwd_src_q <= 1'b0;
    end else if (full_rate) begin
      fwd_src_q <= eq_clk_q;
    end else if (eq_rise) begin
      fwd_src_q <= ~div_q;
    end
  end

  wire fwd_dly;
  stage_delay #(
    .WIDTH(1),
    .DEPTH(`FWD_DELAY_CYC)
  ) u_fwd (
    .clk(clk),
    .arst_n(arst_n),
    .en(1'b1),
    .din(fwd_src_q & run),
    .dout(fwd_dly)
  );

  // The delay line already gives one flop; this adds the pair
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fwd_clock_true <= 1'b0;
      fwd_clock_comp <= 1'b1;
    end else begin
      fwd_clock_true <= fwd_dly;
      fwd_clock_comp <= ~fwd_dly;
    end
  end

  // Avalon-MM slave: one wait state per access
  wire req = read | write;
  wire take = req & ack_q;
  assign waitrequest = req & ~ack_q;

  wire [`ST_W-1:0] events;
  assign events[`ST_RANGE_BIT] = update & pipe_out[`WORD_W];
  assign events[`ST_UPDATE_BIT] = update;
  wire wr_status = take & write & (address == `REG_STATUS) & byteenable[0];
  wire [`ST_W-1:0] clr = wr_status ? writedata[`ST_W-1:0] :
                         {`ST_W{1'b0}};

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      ctrl_q <= `CTRL_RESET;
      status_q <= {`ST_W{1'b0}};
      mask_q <= {`ST_W{1'b0}};
      readdata <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      // A new event wins over a simultaneous clear
      status_q <= (status_q & ~clr) | events;
      if (take & write & byteenable[0]) begin
        if (address == `REG_CTRL) begin
          ctrl_q <= {31'h0000_0000, writedata[`CTRL_RUN_BIT]};
        end
        if (address == `REG_MASK) begin
          mask_q <= writedata[`ST_W-1:0];
        end
      end
      if (read & ~ack_q) begin
        case (address)
          `REG_CTRL: readdata <= ctrl_q;
          `REG_STATUS: readdata <= {30'h0000_0000, status_q};
          `REG_MASK: readdata <= {30'h0000_0000, mask_q};
          `REG_WORD: readdata <= {23'h00_0000, range_flag_true,
                                  sample_word_true};
          `REG_PERIOD: readdata <= {16'h0000, period_q};
          default: readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign irq = |(status_q & mask_q);
endmodule

//--- hw/stage_delay.v
// Parameterised delay line: DEPTH stages of WIDTH bits, advanced by en.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
module stage_delay #(
  parameter WIDTH = 1,
  parameter DEPTH = 1
) (
  input wire clk, // System clock
  input wire arst_n, // Asynchronous reset, active low
  input wire en, // Advance the line by one stage
  input wire [WIDTH-1:0] din, // Data entering the first stage
  output wire [WIDTH-1:0] dout // Data leaving the last stage
);
  reg [WIDTH-1:0] stage_q [0:DEPTH-1];
  integer i;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        stage_q[i] <= {WIDTH{1'b0}};
      end
    end else if (en) begin
      stage_q[0] <= din;
      for (i = 1; i < DEPTH; i = i + 1) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  assign dout = stage_q[DEPTH-1];
endmodule
